// ### src/sld_pkg.sv
package sld_pkg;
   // Register offsets
   localparam logic [7:0] SYS_DIAG_REQUEST_OFS = 8'h36;
   localparam logic [7:0] LOOP_DIAG_STATUS_OFS = 8'h37;
   localparam logic [7:0] LOOP_DIAG_REQUEST_OFS = 8'h38;
   // Loop request field positions
   localparam int LRQ_HIGH_LEVEL_BIT = 15;
   localparam int LRQ_SRC_SEL_BIT    = 14;
   localparam int LRQ_PD_OFF_BIT     = 13;
   localparam int LRQ_SRC_LSB        = 11;
   localparam int LRQ_SINK_BIT       = 10;
   localparam int LRQ_MON_LSB        = 8;
   localparam int LRQ_RES_CH_LSB     = 4;
   localparam int LRQ_LEAK_CH_LSB    = 0;
   localparam logic [1:0] MON_TO_FEED = 2'h1;
   localparam logic [1:0] MON_TO_RETURN = 2'h2;
   localparam logic [1:0] SRC_ON_RES = 2'h1;
   // System request test select
   localparam logic [3:0] TEST_HS_FET = 4'h7;
   // Status bit positions
   localparam int ST_FET_ON_BIT = 15;
   localparam int ST_UPPER_BIT  = 13;
   localparam int ST_LOWER_BIT  = 12;
   localparam int ST_LOOPS_BIT  = 7;
   localparam int ST_GND_BIT    = 6;
   localparam int ST_BAT_BIT    = 5;
   localparam int ST_MON_BIT    = 4;
   // Reset values
   localparam logic [15:0] LOOP_REQ_RST = 16'h2000;
   // Timing
   localparam int CLK_MHZ = 250;
   localparam int FET_TIMEOUT_US = 200;
   localparam int FET_TIMEOUT_CYC = FET_TIMEOUT_US * CLK_MHZ;
   // Operating states
   typedef enum logic [2:0] {
      SLD_ST_INIT, SLD_ST_DIAG, SLD_ST_SAFING, SLD_ST_ARMING, SLD_ST_SCRAP
   } sld_opstate_t;
endpackage

// ### src/sld_fet_timer.sv
`timescale 1ns/10ps
module sld_fet_timer #(
   parameter int TIMEOUT_CYC = 50000
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Control
   input  wire logic start,
   input  wire logic stop,
   // Status
   output logic      expired
);
   localparam int W = $clog2(TIMEOUT_CYC + 1);
   localparam logic [W-1:0] LAST = W'(TIMEOUT_CYC - 1);
   logic [W-1:0] cnt_r;
   logic         run_r;
   wire          at_end = run_r && (cnt_r == LAST);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r   <= '0;
         run_r   <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= at_end && !stop;
         if (start) begin
            cnt_r <= '0;
            run_r <= 1'b1;
         end else if (stop || at_end) begin
            run_r <= 1'b0;
         end else if (run_r) begin
            cnt_r <= cnt_r + W'(1);
         end
      end
   end
endmodule

// ### src/sld_ctrl.sv
// Notes on behaviour
// - Bit 14 picks 40 mA or 8 mA source
// - Bit 10 sink; 9:8=01 monitor on feed
// - Differing channel fields raise no error
// - Compare feed current to 6/0.7 mA thresholds
// - Status 13 upper band, 12 lower band
// - Band results unlatched; host reads before next request
// - Status bits 19:16 read zero
// - FET test runs only in diagnostic state
// - Test select 0111 starts high side FET test
// - Above 1.8 mA turn channel off at once
// - Timeout 200 us ends test, output off
// - Status 15 shows FET on during test
// - Short flags latched, cleared by request write; ground short reads live unless a FET result is held
// - Loop write refused in init; system only diag
`timescale 1ns/10ps
module sld_ctrl #(
   parameter int FET_TIMEOUT_CYC = sld_pkg::FET_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Register port
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic [19:0]      reg_rdata,
   // Operating state of the device
   input  wire logic [2:0]  op_state,
   // Analog comparator inputs (asynchronous)
   input  wire logic        lower_band_cmp,
   input  wire logic        upper_band_cmp,
   input  wire logic        fet_pass_cmp,
   input  wire logic        ground_short_cmp,
   input  wire logic        battery_short_cmp,
   input  wire logic        loop_short_cmp,
   // Analog controls
   output logic             source_current_low,
   output logic [1:0]       source_current_mode,
   output logic [3:0]       resistance_channel_select,
   output logic [3:0]       leakage_channel_select,
   output logic             test_sink_current_en,
   output logic [1:0]       monitor_route,
   output logic             pulldown_off,
   output logic             high_level_diag,
   output logic             fet_drive_on,
   output logic [3:0]       fet_channel
);
   logic [15:0] loop_req_r;
   logic [5:0]  sync1_r;
   logic [5:0]  sync2_r;
   logic        fet_active_flag_r;
   logic        ground_short_flag_r;
   logic        battery_short_flag_r;
   logic        loop_short_flag_r;
   logic        fet_result_r;

   // Inputs from the analog side cross into the clock domain
   // Comparators idle low, so the cleared stages give no false edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {loop_short_cmp, battery_short_cmp, ground_short_cmp,
                     fet_pass_cmp, upper_band_cmp, lower_band_cmp};
         sync2_r <= sync1_r;
      end
   end
   wire lower_band_s = sync2_r[0];
   wire upper_band_s = sync2_r[1];
   wire fet_pass_s   = sync2_r[2];
   wire gnd_s        = sync2_r[3];
   wire bat_s        = sync2_r[4];
   wire loops_s      = sync2_r[5];

   // Compares the device state code with one named state
   function automatic logic state_is(input logic [2:0]            code,
                                     input sld_pkg::sld_opstate_t st);
      state_is = code == 3'(st);
   endfunction

   // Write decode with operating state gating
   wire in_diag  = state_is(op_state, sld_pkg::SLD_ST_DIAG);
   wire in_init  = state_is(op_state, sld_pkg::SLD_ST_INIT);
   wire loop_wr  = reg_wr && reg_addr == sld_pkg::LOOP_DIAG_REQUEST_OFS
                   && !in_init;
   wire sys_wr   = reg_wr && reg_addr == sld_pkg::SYS_DIAG_REQUEST_OFS
                   && in_diag;
   wire fet_start = sys_wr
                    && reg_wdata[3:0] == sld_pkg::TEST_HS_FET;
   wire req_clear = loop_wr || sys_wr;

   // Test ends on threshold, leaving diag, or timeout
   wire fet_expired;
   wire fet_stop = fet_active_flag_r && (fet_pass_s || !in_diag);
   wire fet_end  = fet_stop || fet_expired;
   // Results are taken only when a running test ends
   wire fet_capture = fet_active_flag_r && fet_end;

   // A start while running restarts the count
   sld_fet_timer #(
      .TIMEOUT_CYC (FET_TIMEOUT_CYC)
   ) u_timer (
      .clk     (clk),
      .arst_n  (arst_n),
      .start   (fet_start),
      .stop    (fet_stop),
      .expired (fet_expired)
   );

   // Loop request register; channel fields applied independently
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         loop_req_r <= sld_pkg::LOOP_REQ_RST;
      end else if (loop_wr) begin
         loop_req_r <= reg_wdata;
      end
   end

   // FET activity flag; set by a start, cleared when the test ends
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fet_active_flag_r <= 1'b0;
      end else if (fet_start) begin
         fet_active_flag_r <= 1'b1;
      end else if (fet_end) begin
         fet_active_flag_r <= 1'b0;
      end
   end

   // Flags sample at test end; a capture wins over a clearing write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ground_short_flag_r  <= 1'b0;
         battery_short_flag_r <= 1'b0;
         loop_short_flag_r    <= 1'b0;
      end else if (fet_capture) begin
         ground_short_flag_r  <= gnd_s;
         battery_short_flag_r <= bat_s || fet_pass_s;
         loop_short_flag_r    <= loops_s;
      end else if (req_clear) begin
         ground_short_flag_r  <= 1'b0;
         battery_short_flag_r <= 1'b0;
         loop_short_flag_r    <= 1'b0;
      end
   end

   // A FET result stays on view until the next accepted request write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fet_result_r <= 1'b0;
      end else if (fet_capture) begin
         fet_result_r <= 1'b1;
      end else if (req_clear) begin
         fet_result_r <= 1'b0;
      end
   end

   // Ground short shows live unless a FET result is held
   wire       gnd_view    = fet_result_r ? ground_short_flag_r : gnd_s;
   // Host keeps both channel fields equal; nothing here checks that
   wire [3:0] res_ch_w    = loop_req_r[sld_pkg::LRQ_RES_CH_LSB +: 4];
   wire [3:0] leak_ch_w   = loop_req_r[sld_pkg::LRQ_LEAK_CH_LSB +: 4];
   wire [1:0] mon_route_w = loop_req_r[sld_pkg::LRQ_MON_LSB +: 2];
   wire       mon_feed    = mon_route_w == sld_pkg::MON_TO_FEED;

   // Band results follow comparators live while monitor is on feed, else read zero; never latched
   logic [19:0] status_w;
   always_comb begin
      status_w = '0;
      status_w[sld_pkg::ST_FET_ON_BIT] = fet_active_flag_r;
      status_w[sld_pkg::ST_UPPER_BIT]  = upper_band_s && mon_feed;
      status_w[sld_pkg::ST_LOWER_BIT]  = lower_band_s && mon_feed;
      status_w[11:8] = res_ch_w;
      status_w[sld_pkg::ST_LOOPS_BIT]  = loop_short_flag_r;
      status_w[sld_pkg::ST_GND_BIT]    = gnd_view;
      status_w[sld_pkg::ST_BAT_BIT]    = battery_short_flag_r;
      status_w[sld_pkg::ST_MON_BIT]    = mon_feed;
      status_w[3:0] = leak_ch_w;
   end

   // Only the status word answers a read; other addresses read zero
   wire rd_status = reg_addr == sld_pkg::LOOP_DIAG_STATUS_OFS;

   // Registered outputs
   // Drive falls on the same edge that ends the test, never later
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata                 <= '0;
         source_current_low        <= 1'b0;
         source_current_mode       <= '0;
         resistance_channel_select <= '0;
         leakage_channel_select    <= '0;
         test_sink_current_en      <= 1'b0;
         monitor_route             <= '0;
         pulldown_off              <= 1'b0;
         high_level_diag           <= 1'b0;
         fet_drive_on              <= 1'b0;
         fet_channel               <= '0;
      end else begin
         reg_rdata                 <= rd_status ? status_w : 20'h00000;
         source_current_low        <= loop_req_r[sld_pkg::LRQ_SRC_SEL_BIT];
         source_current_mode       <= loop_req_r[sld_pkg::LRQ_SRC_LSB +: 2];
         resistance_channel_select <= res_ch_w;
         leakage_channel_select    <= leak_ch_w;
         test_sink_current_en      <= loop_req_r[sld_pkg::LRQ_SINK_BIT];
         monitor_route             <= mon_route_w;
         pulldown_off              <= loop_req_r[sld_pkg::LRQ_PD_OFF_BIT];
         high_level_diag           <= loop_req_r[sld_pkg::LRQ_HIGH_LEVEL_BIT];
         fet_drive_on              <= fet_start || (fet_active_flag_r && !fet_end);
         fet_channel               <= leak_ch_w;
      end
   end
endmodule

// ### tb/sld_ctrl_props.sv
`timescale 1ns/10ps
module sld_ctrl_props #(
   parameter int FET_TIMEOUT_CYC = sld_pkg::FET_TIMEOUT_CYC
) (
   // Clock, reset and register port
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [19:0] reg_rdata,
   input wire logic [2:0]  op_state,
   // Loop side
   input wire logic        fet_pass_cmp,
   input wire logic        source_current_low,
   input wire logic        test_sink_current_en,
   input wire logic [1:0]  monitor_route,
   input wire logic        pulldown_off,
   input wire logic        fet_drive_on
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [15:0] on_cnt_r;
   wire lp_wr = reg_wr && reg_addr == 8'h38;
   wire fet_go = reg_wr && reg_addr == 8'h36 && reg_wdata[3:0] == 4'h7;
   wire in_diag = op_state == 3'h1;
   sequence lp_take; lp_wr && op_state != 3'h0; endsequence
   sequence pass_held; fet_pass_cmp[*4] and !reg_wr[*4]; endsequence
   // Length of the current drive period, restarted by a new start
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) on_cnt_r <= 16'h0;
      else on_cnt_r <= (fet_drive_on && !fet_go) ? on_cnt_r + 16'h1 : 16'h0;
   chk_src_select: assert property (
      lp_take |-> ##2 source_current_low == $past(reg_wdata[14], 2)) else $error("source select");
   chk_sink_route: assert property (
      lp_take |-> ##2 test_sink_current_en == $past(reg_wdata[10], 2)
         && monitor_route == $past(reg_wdata[9:8], 2)) else $error("sink or monitor route");
   chk_init_refuse: assert property (
      lp_wr && op_state == 3'h0 && !$past(reg_wr) |-> ##2 $stable(pulldown_off))
      else $error("loop write taken in init");
   chk_fet_start: assert property (fet_go && in_diag |=> fet_drive_on)
      else $error("fet test not started");
   chk_fet_refuse: assert property (fet_go && !in_diag && !fet_drive_on |=> !fet_drive_on)
      else $error("fet test started outside diag");
   chk_status_word: assert property (reg_addr == 8'h37 |=> reg_rdata[19:16] == 4'h0
      && reg_rdata[15] == $past(fet_drive_on) && reg_rdata[4] == (monitor_route == 2'h1))
      else $error("status word");
   chk_pass_stop: assert property (pass_held |-> !fet_drive_on)
      else $error("drive not stopped by pass current");
   chk_fet_bound: assert property (on_cnt_r <= FET_TIMEOUT_CYC + 1)
      else $error("fet drive outlives timeout");
endmodule
bind sld_ctrl sld_ctrl_props #(.FET_TIMEOUT_CYC(FET_TIMEOUT_CYC)) sld_ctrl_props_inst (.*);

// ### tb/sld_loop_model.sv
`timescale 1ns/10ps
module sld_loop_model (
   // Clock and drive from the block
   input  wire logic clk,
   input  wire logic fet_drive_on,
   // Load condition chosen by the bench
   input  wire logic fet_good,
   // Comparator output
   output logic      fet_pass_cmp
);
   logic [2:0] dly_r = 3'h0;
   // Current builds up a few cycles after a healthy high side turns on
   always_ff @(posedge clk)
      dly_r <= {dly_r[1:0], fet_drive_on && fet_good};
   assign fet_pass_cmp = dly_r[2];
endmodule

// ### tb/squib_loop_diag_control_test.sv
`timescale 1ns/10ps
module squib_loop_diag_control_test;
   logic        clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, fet_good = 1'h0, pass_c;
   logic        lower_c = 1'h0, upper_c = 1'h0, gnd_c = 1'h0, bat_c = 1'h0, loop_c = 1'h0;
   logic [7:0]  reg_addr = 8'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic [2:0]  op_state = 3'h0;
   logic [19:0] reg_rdata;
   logic        src_low, sink_en, pd_off, fet_on, hi_lvl;
   logic [1:0]  mon_rt, src_mode;
   logic [3:0]  res_ch, leak_ch, fet_ch;
   int          fail_count = 0, checked = 0, n;
   sld_ctrl #(.FET_TIMEOUT_CYC(20)) sld_ctrl_inst (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .op_state(op_state),
      .lower_band_cmp(lower_c), .upper_band_cmp(upper_c), .fet_pass_cmp(pass_c),
      .ground_short_cmp(gnd_c), .battery_short_cmp(bat_c), .loop_short_cmp(loop_c),
      .source_current_low(src_low), .source_current_mode(src_mode),
      .resistance_channel_select(res_ch), .leakage_channel_select(leak_ch),
      .test_sink_current_en(sink_en), .monitor_route(mon_rt), .pulldown_off(pd_off),
      .high_level_diag(hi_lvl), .fet_drive_on(fet_on), .fet_channel(fet_ch));
   sld_loop_model sld_loop_model_inst (.clk(clk), .fet_drive_on(fet_on), .fet_good(fet_good),
      .fet_pass_cmp(pass_c));
   initial forever #2 clk = ~clk;
   task automatic close_out;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_wr = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'h0;
      repeat (2) @(negedge clk);
   endtask
   task automatic rd(input logic [19:0] m, input logic [19:0] e);
      @(negedge clk);
      reg_addr = 8'h37;
      repeat (4) @(negedge clk);
      chk(reg_rdata & m, e);
   endtask
   task automatic wait_off(output int c);
      c = 0;
      while (fet_on === 1'h1 && c < 200) begin
         @(negedge clk);
         c++;
      end
      if (c >= 200) begin
         fail_count++;
         close_out;
      end
   endtask
   initial begin
      repeat (3) @(negedge clk);
      arst_n = 1'h1;
      rd(20'hFB0F0, 20'h0);
      wr(8'h38, 16'h0000);
      chk(pd_off, 1'h1);
      wr(8'h36, 16'h0007);
      chk(fet_on, 1'h0);
      op_state = 3'h1;
      wr(8'h38, 16'h6523);
      chk({src_low, sink_en, mon_rt, res_ch, leak_ch}, 20'hD23);
      upper_c = 1'h1;
      rd(20'h03050, 20'h02010);
      upper_c = 1'h0;
      lower_c = 1'h1;
      gnd_c = 1'h1;
      rd(20'h03050, 20'h01050);
      gnd_c = 1'h0;
      wr(8'h38, 16'h2100);
      chk(src_low, 1'h0);
      fet_good = 1'h1;
      wr(8'h36, 16'h0007);
      chk(fet_on, 1'h1);
      wait_off(n);
      chk(n < 10, 1'h1);
      rd(20'h080F0, 20'h00030);
      wr(8'h38, 16'h2100);
      rd(20'h00060, 20'h0);
      fet_good = 1'h0;
      gnd_c = 1'h1;
      loop_c = 1'h1;
      wr(8'h36, 16'h0007);
      rd(20'h08000, 20'h08000);
      wait_off(n);
      chk(n > 11 && n < 18, 1'h1);
      gnd_c = 1'h0;
      loop_c = 1'h0;
      rd(20'h080E0, 20'h000C0);
      op_state = 3'h2;
      wr(8'h36, 16'h0007);
      rd(20'h08040, 20'h00040);
      wr(8'h38, 16'hD912);
      chk(src_low, 1'h1);
      chk({hi_lvl, pd_off, src_mode, fet_ch}, 20'h000B2);
      close_out;
   end
endmodule
